// ---- hw/ccb_pkg.sv ----
// constants and types for the custom machine-level csr block
// Summary of operation
// - scratchpad base is a 64-bit read/write register, no reset value.
// - geometry bit 31 reads one when a second-level cache is present.
// - icache set code bits 24:22, sets 2**(code+6), code 7 means 32.
// - icache line code bits 21:19, zero bytes or 2**(code+1) bytes.
// - icache way code bits 18:16 holds ways minus one.
// - dcache set code bits 15:13, sets 2**(code+6), code 7 means 32.
// - dcache line code bits 12:10, zero bytes or 2**(code+1) bytes.
// - dcache way code bits 9:7 holds ways minus one.
// - bit 14 flags global non-leaf miss, writable only with software walker.
// - miss kind bits 13:12: instruction, load, store; code 10 reserved.
// - translation target bits 11:10 loaded with missing type on tlb miss.
// - page level bits 9:7 set on miss; writes keep only legal levels.
// - bit 6 captures gva on qualifying traps; mret then sets gva.
// - bit 5 is write-one-set, locks diagnostic instructions until reset.
// - bit 4 captures mpv on qualifying traps; mret then sets mpv.
// - bit 3 captures mpp supervisor on qualifying traps; mret sets mpp.
// - bit 2 steers m-mode accesses; cleared by traps, restored by mret.
// - bit 1 saves walk bit before the latest m-mode trap.
// - error level bit 0 set on nmi or cache error, cleared by returns.
// - while error level set, accesses uncached, interrupts but nmi masked.
package ccb_pkg;
  // ****************************************
  // register addresses
  // ****************************************
  localparam logic [11:0] ADDR_SCRATCH = 12'h07cc;
  localparam logic [11:0] ADDR_GEOM = 12'h07d1;
  localparam logic [11:0] ADDR_WALK = 12'h07d5;
  // ****************************************
  // field positions
  // ****************************************
  localparam int GEO_L2 = 31;
  localparam int GEO_IS = 22;
  localparam int GEO_IL = 19;
  localparam int GEO_IA = 16;
  localparam int GEO_DS = 13;
  localparam int GEO_DL = 10;
  localparam int GEO_DA = 7;
  localparam int WS_G = 14;
  localparam int WS_KIND = 12;
  localparam int WS_TRANSLATION_TARGET = 10;
  localparam int WS_LVL = 7;
  localparam int WS_PRIOR_GUEST_ADDR_FLAG = 6;
  localparam int WS_LOCK = 5;
  localparam int WS_PPV = 4;
  localparam int WS_PPS = 3;
  localparam int WS_MTW = 2;
  localparam int WS_PTW = 1;
  localparam int WS_ERL = 0;
  localparam logic [31:0] WS_MASK = 32'h0000_7fff;
  localparam logic [1:0] KIND_RSVD = 2'h2;
  localparam logic [1:0] TRANSLATION_TARGET_RSVD = 2'h3;
  localparam logic [1:0] PRIV_S = 2'h1;
  // reset value of bits 6:0; upper fields undefined, held as zero
  localparam logic [31:0] WS_RESET = 32'h0000_0000;
  typedef enum logic [1:0] {CCB_IDLE, CCB_DONE} ccb_state_e;
endpackage : ccb_pkg

// ---- hw/ccb_geom.sv ----
// read-only cache geometry word from configuration
module ccb_geom #(
  parameter bit L2_PRESENT = 1'b1,
  parameter logic [2:0] IS_CODE = 3'h2,
  parameter logic [2:0] IL_CODE = 3'h5,
  parameter logic [2:0] IA_CODE = 3'h3,
  parameter logic [2:0] DS_CODE = 3'h2,
  parameter logic [2:0] DL_CODE = 3'h5,
  parameter logic [2:0] DA_CODE = 3'h3
) (
  output logic [31:0] geom
);
  always_comb begin
    geom = 32'h0000_0000;
    geom[ccb_pkg::GEO_L2] = L2_PRESENT;
    geom[ccb_pkg::GEO_IS +: 3] = IS_CODE;
    geom[ccb_pkg::GEO_IL +: 3] = IL_CODE;
    geom[ccb_pkg::GEO_IA +: 3] = IA_CODE;
    geom[ccb_pkg::GEO_DS +: 3] = DS_CODE;
    geom[ccb_pkg::GEO_DL +: 3] = DL_CODE;
    geom[ccb_pkg::GEO_DA +: 3] = DA_CODE;
  end
endmodule // ccb_geom

// ---- hw/ccb_lvl.sv ----
// legalises a written page level for the supported walker modes
module ccb_lvl #(
  parameter logic [2:0] MAX_LEVEL = 3'h3
) (
  input wire logic [2:0] wr_level,
  input wire logic [2:0] old_level,
  output logic [2:0] legal_level
);
  // illegal writes keep the old value, the usual warl trade
  always_comb begin
    legal_level = (wr_level <= MAX_LEVEL) ? wr_level : old_level;
  end
endmodule // ccb_lvl

// ---- hw/ccb_top.sv ----
// custom machine-level csr block: scratchpad base, geometry, walker state
module ccb_top #(
  parameter bit SW_WALKER = 1'b1,
  parameter bit H_EXT = 1'b1,
  parameter logic [2:0] MAX_LEVEL = 3'h3
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic csr_rd,
  input wire logic csr_wr,
  input wire logic [11:0] csr_addr,
  input wire logic [63:0] csr_wdata,
  output logic [63:0] csr_rdata,
  output logic csr_ack,
  output logic csr_err,
  input wire logic trap_m,
  input wire logic trap_custom_vec,
  input wire logic trap_nmi_cerr,
  input wire logic tlb_miss,
  input wire logic tlb_miss_global,
  input wire logic [1:0] tlb_miss_kind,
  input wire logic [1:0] tlb_miss_translation_target,
  input wire logic [2:0] tlb_miss_level,
  input wire logic status_gva,
  input wire logic status_mpv,
  input wire logic [1:0] status_mpp,
  input wire logic mret,
  input wire logic sret,
  output logic ret_set_gva,
  output logic ret_set_mpv,
  output logic ret_set_mpp_s,
  output logic walk_mode,
  output logic diag_lock,
  output logic force_uncached,
  output logic irq_mask_all
);
  // ****************************************
  // state
  // ****************************************
  logic [63:0] scratch_q, scratch_d;
  logic [31:0] ws_q, ws_d;
  logic [63:0] rdata_q, rdata_d;
  logic ack_q, ack_d, err_q, err_d;
  logic [31:0] geom;
  logic [2:0] legal_level;
  logic hit_s, hit_g, hit_w, qual;

  ccb_geom u_geom (
    .geom(geom)
  );

  ccb_lvl #(.MAX_LEVEL(MAX_LEVEL)) u_lvl (
    .wr_level(csr_wdata[ccb_pkg::WS_LVL +: 3]),
    .old_level(ws_q[ccb_pkg::WS_LVL +: 3]),
    .legal_level(legal_level)
  );

  assign hit_s = csr_addr == ccb_pkg::ADDR_SCRATCH;
  assign hit_g = csr_addr == ccb_pkg::ADDR_GEOM;
  assign hit_w = csr_addr == ccb_pkg::ADDR_WALK;
  // trap qualifies when taken via custom vector or with walk bit set
  assign qual = trap_m && (trap_custom_vec || ws_q[ccb_pkg::WS_MTW]);

  // ****************************************
  // register updates
  // ****************************************
  always_comb begin
    scratch_d = scratch_q;
    ws_d = ws_q;
    // software writes first; hardware events below override them
    if (csr_wr && hit_s) begin
      scratch_d = csr_wdata;
    end
    if (csr_wr && hit_w) begin
      if (SW_WALKER) begin
        ws_d[ccb_pkg::WS_G] = csr_wdata[ccb_pkg::WS_G];
        if (csr_wdata[ccb_pkg::WS_KIND +: 2] != ccb_pkg::KIND_RSVD) begin
          ws_d[ccb_pkg::WS_KIND +: 2] =
            csr_wdata[ccb_pkg::WS_KIND +: 2];
        end
        if (csr_wdata[ccb_pkg::WS_TRANSLATION_TARGET +: 2] != ccb_pkg::TRANSLATION_TARGET_RSVD) begin
          ws_d[ccb_pkg::WS_TRANSLATION_TARGET +: 2] =
            csr_wdata[ccb_pkg::WS_TRANSLATION_TARGET +: 2];
        end
        ws_d[ccb_pkg::WS_LVL +: 3] = legal_level;
        ws_d[ccb_pkg::WS_PPS] = csr_wdata[ccb_pkg::WS_PPS];
        ws_d[ccb_pkg::WS_MTW] = csr_wdata[ccb_pkg::WS_MTW];
        ws_d[ccb_pkg::WS_PTW] = csr_wdata[ccb_pkg::WS_PTW];
        if (H_EXT) begin
          ws_d[ccb_pkg::WS_PRIOR_GUEST_ADDR_FLAG] = csr_wdata[ccb_pkg::WS_PRIOR_GUEST_ADDR_FLAG];
          ws_d[ccb_pkg::WS_PPV] = csr_wdata[ccb_pkg::WS_PPV];
        end
      end
      if (csr_wdata[ccb_pkg::WS_LOCK]) begin
        ws_d[ccb_pkg::WS_LOCK] = 1'b1;
      end
      ws_d[ccb_pkg::WS_ERL] = csr_wdata[ccb_pkg::WS_ERL];
    end
    if (tlb_miss && SW_WALKER) begin
      ws_d[ccb_pkg::WS_G] = tlb_miss_global;
      ws_d[ccb_pkg::WS_KIND +: 2] = tlb_miss_kind;
      ws_d[ccb_pkg::WS_TRANSLATION_TARGET +: 2] = tlb_miss_translation_target;
      ws_d[ccb_pkg::WS_LVL +: 3] = tlb_miss_level;
    end
    if ((mret || sret) && !trap_m) begin
      ws_d[ccb_pkg::WS_ERL] = 1'b0;
    end
    if (mret && !trap_m && SW_WALKER) begin
      ws_d[ccb_pkg::WS_MTW] = ws_q[ccb_pkg::WS_PTW];
    end
    if (trap_m && SW_WALKER) begin
      ws_d[ccb_pkg::WS_PTW] = ws_q[ccb_pkg::WS_MTW];
      ws_d[ccb_pkg::WS_MTW] = 1'b0;
      if (qual) begin
        ws_d[ccb_pkg::WS_PPS] = status_mpp == ccb_pkg::PRIV_S;
        if (H_EXT) begin
          ws_d[ccb_pkg::WS_PRIOR_GUEST_ADDR_FLAG] = status_gva;
          ws_d[ccb_pkg::WS_PPV] = status_mpv;
        end
      end
    end
    if (trap_nmi_cerr) begin
      ws_d[ccb_pkg::WS_ERL] = 1'b1;
    end
    ws_d = ws_d & ccb_pkg::WS_MASK;
  end

  // ****************************************
  // read path
  // ****************************************
  always_comb begin
    rdata_d = 64'h0000_0000_0000_0000;
    ack_d = csr_rd || csr_wr;
    err_d = (csr_rd || csr_wr) && !(hit_s || hit_g || hit_w);
    if (csr_rd) begin
      if (hit_s) begin
        rdata_d = scratch_q;
      end else if (hit_g) begin
        rdata_d = {32'h0000_0000, geom};
      end else if (hit_w) begin
        rdata_d = {32'h0000_0000, ws_q & ccb_pkg::WS_MASK};
      end
    end
    // geometry is read-only: writes are acknowledged, refused via err
    if (csr_wr && hit_g) begin
      err_d = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    // scratchpad base has no reset value by design
    scratch_q <= scratch_d;
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ws_q <= ccb_pkg::WS_RESET;
      rdata_q <= 64'h0000_0000_0000_0000;
      ack_q <= 1'b0;
      err_q <= 1'b0;
      ret_set_gva <= 1'b0;
      ret_set_mpv <= 1'b0;
      ret_set_mpp_s <= 1'b0;
      walk_mode <= 1'b0;
      diag_lock <= 1'b0;
      force_uncached <= 1'b0;
      irq_mask_all <= 1'b0;
    end else begin
      ws_q <= ws_d;
      rdata_q <= rdata_d;
      ack_q <= ack_d;
      err_q <= err_d;
      ret_set_gva <= ws_d[ccb_pkg::WS_PRIOR_GUEST_ADDR_FLAG];
      ret_set_mpv <= ws_d[ccb_pkg::WS_PPV];
      ret_set_mpp_s <= ws_d[ccb_pkg::WS_PPS];
      walk_mode <= ws_d[ccb_pkg::WS_MTW];
      diag_lock <= ws_d[ccb_pkg::WS_LOCK];
      force_uncached <= ws_d[ccb_pkg::WS_ERL];
      irq_mask_all <= ws_d[ccb_pkg::WS_ERL];
    end
  end

  assign csr_rdata = rdata_q;
  assign csr_ack = ack_q;
  assign csr_err = err_q;

  // ****************************************
  // checks
  // ****************************************
  erl_set_a: assert property (@(posedge mclk)
    disable iff (!resetn) trap_nmi_cerr |=> ws_q[0] && force_uncached)
    else $error("error level not set");
  erl_clear_a: assert property (@(posedge mclk)
    disable iff (!resetn) (mret && !trap_m && !trap_nmi_cerr) |=> !ws_q[0])
    else $error("error level not cleared");
  erl_mask_a: assert property (@(posedge mclk)
    disable iff (!resetn) irq_mask_all == ws_q[0])
    else $error("interrupt mask mismatch");
  lock_sticky_a: assert property (@(posedge mclk)
    disable iff (!resetn) diag_lock |=> diag_lock)
    else $error("diagnostic lock dropped");
  trap_walk_a: assert property (@(posedge mclk)
    disable iff (!resetn) trap_m |=> !walk_mode && ws_q[1] == $past(ws_q[2]))
    else $error("walk bit not saved on trap");
  mret_walk_a: assert property (@(posedge mclk)
    disable iff (!resetn) (mret && !trap_m) |=> walk_mode == $past(ws_q[1]))
    else $error("walk bit not restored");
  pps_cap_a: assert property (@(posedge mclk)
    disable iff (!resetn) (trap_m && trap_custom_vec)
    |=> ret_set_mpp_s == ($past(status_mpp) == ccb_pkg::PRIV_S))
    else $error("prior supervisor not captured");
  miss_kind_a: assert property (@(posedge mclk)
    disable iff (!resetn) tlb_miss |=> ws_q[13:12] == $past(tlb_miss_kind))
    else $error("miss kind not recorded");
  rsvd_zero_a: assert property (@(posedge mclk)
    disable iff (!resetn) ws_q[31:15] == 17'h0_0000)
    else $error("reserved bits nonzero");
endmodule // ccb_top

// ---- verif/testbench.sv ----
// self-checking bench for the custom machine-level csr block
`define CHK(nm, ex, got) begin \
  check_count++; \
  if ((got) !== (ex)) begin \
    fail_count++; \
    $display("MISMATCH %s expected %h seen %h", nm, ex, got); \
  end \
end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // stimulus, design and model state
  // ****************************************
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic csr_rd = 1'b0, csr_wr = 1'b0, tlb_miss_global = 1'b0;
  logic trap_custom_vec = 1'b0, status_gva = 1'b0, status_mpv = 1'b0;
  logic [11:0] csr_addr = 12'h000;
  logic [63:0] csr_wdata = 64'h0000_0000_0000_0000, csr_rdata, sp_m;
  logic [1:0] tlb_miss_kind = 2'h0, tlb_miss_translation_target = 2'h0, status_mpp = 2'h0;
  logic [2:0] tlb_miss_level = 3'h0;
  logic [4:0] ev_q = 5'h00; // trap_m, nmi/cerr, mret, sret, tlb miss
  logic csr_ack, csr_err, ret_set_gva, ret_set_mpv, ret_set_mpp_s;
  logic walk_mode, diag_lock, force_uncached, irq_mask_all;
  logic [31:0] ws_m = 32'h0000_0000, lfsr_q = 32'h7279_bc12, d;
  int fail_count = 0, check_count = 0;
  // fixed configuration of the geometry word, fields high to low
  localparam logic [31:0] GEO = {1'b1, 6'h00, 3'h2, 3'h5, 3'h3, 3'h2, 3'h5,
    3'h3, 7'h00};
  ccb_top DUT (.mclk(mclk), .resetn(resetn), .csr_rd(csr_rd),
    .csr_wr(csr_wr), .csr_addr(csr_addr), .csr_wdata(csr_wdata),
    .csr_rdata(csr_rdata), .csr_ack(csr_ack), .csr_err(csr_err),
    .trap_m(ev_q[0]), .trap_custom_vec(trap_custom_vec),
    .trap_nmi_cerr(ev_q[1]), .tlb_miss(ev_q[4]),
    .tlb_miss_global(tlb_miss_global), .tlb_miss_kind(tlb_miss_kind),
    .tlb_miss_translation_target(tlb_miss_translation_target), .tlb_miss_level(tlb_miss_level),
    .status_gva(status_gva), .status_mpv(status_mpv),
    .status_mpp(status_mpp), .mret(ev_q[2]), .sret(ev_q[3]),
    .ret_set_gva(ret_set_gva), .ret_set_mpv(ret_set_mpv),
    .ret_set_mpp_s(ret_set_mpp_s), .walk_mode(walk_mode),
    .diag_lock(diag_lock), .force_uncached(force_uncached),
    .irq_mask_all(irq_mask_all));
  always #50 mclk = ~mclk;
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    lfsr_q = {lfsr_q[30:0], 1'b0} ^ (lfsr_q[31] ? 32'h0040_0007 : 32'h0);
    return lfsr_q;
  endfunction
  // software write: lock only sets, illegal codes keep the old field
  function automatic logic [31:0] ws_wr(logic [31:0] o, logic [31:0] v);
    logic [31:0] n;
    n = (v & ccb_pkg::WS_MASK) | (o & 32'h0000_0020);
    if (v[13:12] == 2'h2) n[13:12] = o[13:12];
    if (v[11:10] == 2'h3) n[11:10] = o[11:10];
    if (v[9:7] > 3'h3) n[9:7] = o[9:7];
    return n;
  endfunction
  task automatic flags();
    logic [6:0] ex, got;
    ex = {ws_m[6], ws_m[4], ws_m[3], ws_m[2], ws_m[5], ws_m[0], ws_m[0]};
    got = {ret_set_gva, ret_set_mpv, ret_set_mpp_s, walk_mode, diag_lock,
      force_uncached, irq_mask_all};
    `CHK("flags", ex, got)
  endtask
  task automatic csr(logic w, logic [11:0] a, logic [63:0] v,
    logic [63:0] er, logic ee);
    @(posedge mclk);
    {csr_wr, csr_rd} <= {w, !w};
    csr_addr <= a;
    csr_wdata <= v;
    @(posedge mclk);
    {csr_wr, csr_rd} <= 2'b00;
    #1;
    `CHK("ack", 1'b1, csr_ack)
    `CHK("err", ee, csr_err)
    if (!w) `CHK("rdata", er, csr_rdata)
  endtask
  task automatic rd_ws();
    csr(1'b0, ccb_pkg::ADDR_WALK, 64'h0, {32'h0, ws_m}, 1'b0);
    flags();
  endtask
  // one event cycle; trap beats mret, nmi beats returns
  task automatic pulse(logic [4:0] e);
    @(posedge mclk);
    ev_q <= e;
    @(posedge mclk);
    ev_q <= 5'h00;
    #1;
    if (e[4]) begin
      ws_m[14:7] = {tlb_miss_global, tlb_miss_kind, tlb_miss_translation_target,
        tlb_miss_level};
    end
    if (e[2] && !e[0]) ws_m[2] = ws_m[1];
    if ((e[2] || e[3]) && !e[0]) ws_m[0] = 1'b0;
    if (e[0]) begin
      if (trap_custom_vec || ws_m[2]) begin
        ws_m[6] = status_gva;
        ws_m[4] = status_mpv;
        ws_m[3] = status_mpp == ccb_pkg::PRIV_S;
      end
      ws_m[1] = ws_m[2];
      ws_m[2] = 1'b0;
    end
    if (e[1]) ws_m[0] = 1'b1;
    flags();
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ****************************************
  // tests
  // ****************************************
  initial begin
    #400000;
    fail_count++;
    complete_run();
  end
  initial begin
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    rd_ws();
    csr(1'b0, ccb_pkg::ADDR_GEOM, 64'h0, {32'h0, GEO}, 1'b0);
    csr(1'b1, ccb_pkg::ADDR_GEOM, 64'hffff_ffff, 64'h0, 1'b1);
    csr(1'b0, ccb_pkg::ADDR_GEOM, 64'h0, {32'h0, GEO}, 1'b0);
    csr(1'b0, 12'h7d2, 64'h0, 64'h0, 1'b1);
    $display("test reset and geometry done");
    for (int i = 0; i < 4; i++) begin
      sp_m = {rnd(), rnd()};
      csr(1'b1, ccb_pkg::ADDR_SCRATCH, sp_m, 64'h0, 1'b0);
      csr(1'b0, ccb_pkg::ADDR_SCRATCH, 64'h0, sp_m, 1'b0);
    end
    $display("test scratchpad done");
    for (int i = 0; i < 16; i++) begin
      d = rnd();
      csr(1'b1, ccb_pkg::ADDR_WALK, {rnd(), d}, 64'h0, 1'b0);
      ws_m = ws_wr(ws_m, d);
      rd_ws();
    end
    $display("test walker writes done");
    for (int i = 0; i < 6; i++) begin
      d = rnd();
      @(posedge mclk);
      tlb_miss_global <= d[0];
      tlb_miss_kind <= (i % 3 == 2) ? 2'h3 : 2'(i % 3);
      tlb_miss_translation_target <= 2'(i % 3);
      tlb_miss_level <= {1'b0, d[5:4]};
      pulse(5'h10);
      rd_ws();
    end
    $display("test tlb miss done");
    csr(1'b1, ccb_pkg::ADDR_WALK, 64'h4, 64'h0, 1'b0);
    ws_m = ws_wr(ws_m, 32'h0000_0004);
    @(posedge mclk);
    {status_gva, status_mpv, status_mpp} <= 4'b1101;
    pulse(5'h01);
    pulse(5'h04);
    rd_ws();
    csr(1'b1, ccb_pkg::ADDR_WALK, 64'h0, 64'h0, 1'b0);
    ws_m = ws_wr(ws_m, 32'h0);
    pulse(5'h01);
    @(posedge mclk);
    trap_custom_vec <= 1'b1;
    pulse(5'h01);
    // a later capture with clear status fields must clear the saved bits
    @(posedge mclk);
    {status_gva, status_mpv, status_mpp} <= 4'b0000;
    pulse(5'h01);
    @(posedge mclk);
    trap_custom_vec <= 1'b0;
    pulse(5'h05);
    rd_ws();
    $display("test trap and return done");
    pulse(5'h02);
    pulse(5'h04);
    pulse(5'h0a);
    pulse(5'h09);
    pulse(5'h08);
    rd_ws();
    $display("test error level done");
    csr(1'b1, ccb_pkg::ADDR_WALK, 64'h20, 64'h0, 1'b0);
    ws_m = ws_wr(ws_m, 32'h0000_0020);
    csr(1'b1, ccb_pkg::ADDR_WALK, 64'h0, 64'h0, 1'b0);
    ws_m = ws_wr(ws_m, 32'h0);
    rd_ws();
    @(posedge mclk);
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    ws_m = ccb_pkg::WS_RESET;
    rd_ws();
    $display("test lock and second reset done");
    complete_run();
  end
endmodule // testbench
